/* wsc_defs.svh */
`ifndef WSC_DEFS_SVH
`define WSC_DEFS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define WSC_CLK_MHZ        40
`define WSC_CLK_PERIOD_NS  25

// ----------------------------------------------------------------
// wake input timing
// ----------------------------------------------------------------
`define WSC_WAKE_MIN_US    40
`define WSC_WAKE_MIN_CYC   (`WSC_WAKE_MIN_US * `WSC_CLK_MHZ)
`define WSC_EDGE_RISE_US   10
`define WSC_EDGE_HIGH_US   20
`define WSC_CNT_W          12

// ----------------------------------------------------------------
// transition phase and reset pulse
// ----------------------------------------------------------------
`define WSC_TRANS_CYC      16
`define WSC_TRANS_W        5
`define WSC_RST_CYC        8
`define WSC_RST_W          4

// ----------------------------------------------------------------
// input synchroniser
// ----------------------------------------------------------------
`define WSC_SYNC_RST_VAL   1'b0

`endif

/* wsc_pkg.sv */
package wsc_pkg;

  // ----------------------------------------------------------------
  // power states, gray along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WSC_ST_INIT     = 3'h0,
    WSC_ST_NORMAL   = 3'h1,
    WSC_ST_TO_SLEEP = 3'h3,
    WSC_ST_SLEEP    = 3'h2,
    WSC_ST_WAKE     = 3'h6,
    WSC_ST_TO_STBY  = 3'h7,
    WSC_ST_STANDBY  = 3'h5,
    WSC_ST_FAILSAFE = 3'h4
  } wsc_state_t;

  // ----------------------------------------------------------------
  // host command codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WSC_CMD_NORMAL  = 2'h0,
    WSC_CMD_SLEEP   = 2'h1,
    WSC_CMD_STANDBY = 2'h2,
    WSC_CMD_NONE    = 2'h3
  } wsc_cmd_code_t;

  typedef struct packed {
    logic          valid;
    wsc_cmd_code_t code;
  } wsc_cmd_t;

endpackage

/* wsc_in_sync.sv */
`timescale 1ns/100ps
`include "wsc_defs.svh"

// ----------------------------------------------------------------
// three stage synchroniser with agreement filter
// ----------------------------------------------------------------
module wsc_in_sync (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);

  logic s1;
  logic s2;
  logic s3;

  // ----------------------------------------------------------------
  // flop chain
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= `WSC_SYNC_RST_VAL;
      s2 <= `WSC_SYNC_RST_VAL;
      s3 <= `WSC_SYNC_RST_VAL;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // ----------------------------------------------------------------
  // filtered level and rising edge pulse
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      level <= `WSC_SYNC_RST_VAL;
      rise  <= 1'b0;
    end else begin
      if (s2 == s3) begin
        level <= s3;
      end
      rise <= (s2 == s3) && s3 && !level;
    end
  end

endmodule

/* wsc_wake_ctrl.sv */
`timescale 1ns/100ps
`include "wsc_defs.svh"

// How it works
// - power-on reset lands in init state
// - init leaves to normal only on command
// - normal or wake commanded into sleep/standby
// - wake level held long enough is wake
// - enable rising edge is a wake
// - wake: standby/failsafe to init, sleep to wake
// - low level or falling edge does nothing
// - wake during sleep entry: wake plus interrupt
// - wake during standby entry: init plus reset
// - low-power command works with enable high
module wsc_wake_ctrl #(
  parameter int WAKE_MIN_CYC = `WSC_WAKE_MIN_CYC,
  parameter int CNT_W        = `WSC_CNT_W,
  parameter int TRANS_CYC    = `WSC_TRANS_CYC,
  parameter int RST_CYC      = `WSC_RST_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire wsc_pkg::wsc_cmd_t  host_cmd,
  input  wire logic               failsafe_req,
  input  wire logic               wake_level_input,
  input  wire logic               enable_edge_input,
  output wsc_pkg::wsc_state_t     state,
  output logic                    wake_irq,
  output logic                    reset_output_n
);

  localparam logic [CNT_W-1:0] WAKE_LIM = CNT_W'(WAKE_MIN_CYC);
  localparam logic [`WSC_TRANS_W-1:0] TRANS_LAST =
    `WSC_TRANS_W'(TRANS_CYC - 1);
  localparam logic [`WSC_RST_W-1:0] RST_LOAD = `WSC_RST_W'(RST_CYC);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (WAKE_MIN_CYC < 2 || WAKE_MIN_CYC >= (1 << CNT_W)) begin : g_bad_wake
    $error("wake minimum count does not fit counter");
  end
  if (TRANS_CYC < 2 || TRANS_CYC > (1 << `WSC_TRANS_W)) begin : g_bad_trans
    $error("transition length does not fit counter");
  end
  if (RST_CYC < 4 || RST_CYC >= (1 << `WSC_RST_W)) begin : g_bad_rst
    $error("reset pulse length does not fit counter");
  end

  wsc_pkg::wsc_state_t    next_state;
  logic                   wake_lvl;
  logic                   edge_lvl;
  logic                   edge_rise;
  logic [CNT_W-1:0]       lvl_cnt;
  logic                   wake_lvl_ok;
  logic                   wake_evt;
  logic [`WSC_TRANS_W-1:0] trans_cnt;
  logic                   trans_done;
  logic                   next_irq;
  logic                   next_rst;
  logic [`WSC_RST_W-1:0]  rst_cnt;
  logic                   post_rst;
  logic                   cmd_normal;
  logic                   cmd_sleep;
  logic                   cmd_stby;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic logic is_cmd(input wsc_pkg::wsc_cmd_t c,
                                  input wsc_pkg::wsc_cmd_code_t k);
    is_cmd = c.valid && (c.code == k);
  endfunction

  assign cmd_normal = is_cmd(host_cmd, wsc_pkg::WSC_CMD_NORMAL);
  assign cmd_sleep  = is_cmd(host_cmd, wsc_pkg::WSC_CMD_SLEEP);
  assign cmd_stby   = is_cmd(host_cmd, wsc_pkg::WSC_CMD_STANDBY);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // both pins synchronised
  wsc_in_sync u_wake_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   (wake_level_input),
    .level    (wake_lvl),
    .rise     ()
  );

  wsc_in_sync u_edge_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   (enable_edge_input),
    .level    (edge_lvl),
    .rise     (edge_rise)
  );

  // ----------------------------------------------------------------
  // wake level qualification
  // ----------------------------------------------------------------
  // level duration counter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lvl_cnt <= '0;
    end else if (!wake_lvl) begin
      lvl_cnt <= '0;
    end else if (lvl_cnt != WAKE_LIM) begin
      lvl_cnt <= lvl_cnt + CNT_W'(1);
    end
  end

  // low level and falling edge ignored
  assign wake_lvl_ok = wake_lvl && (lvl_cnt == WAKE_LIM);
  assign wake_evt    = wake_lvl_ok || edge_rise;

  // ----------------------------------------------------------------
  // transition phase timer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trans_cnt <= '0;
    end else if (state == wsc_pkg::WSC_ST_TO_SLEEP ||
                 state == wsc_pkg::WSC_ST_TO_STBY) begin
      trans_cnt <= trans_cnt + `WSC_TRANS_W'(1);
    end else begin
      trans_cnt <= '0;
    end
  end

  assign trans_done = (trans_cnt == TRANS_LAST);

  // ----------------------------------------------------------------
  // state decode and register
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_irq   = 1'b0;
    next_rst   = 1'b0;
    if (failsafe_req && state != wsc_pkg::WSC_ST_FAILSAFE) begin
      next_state = wsc_pkg::WSC_ST_FAILSAFE;
    end else begin
      unique case (state)
        wsc_pkg::WSC_ST_INIT: begin
          if (cmd_normal) begin
            next_state = wsc_pkg::WSC_ST_NORMAL;
          end
        end
        wsc_pkg::WSC_ST_NORMAL: begin
          if (cmd_sleep) begin
            next_state = wsc_pkg::WSC_ST_TO_SLEEP;
          end else if (cmd_stby) begin
            next_state = wsc_pkg::WSC_ST_TO_STBY;
          end
        end
        wsc_pkg::WSC_ST_TO_SLEEP: begin
          if (wake_evt) begin
            next_state = wsc_pkg::WSC_ST_WAKE;
            next_irq   = 1'b1;
          end else if (trans_done) begin
            next_state = wsc_pkg::WSC_ST_SLEEP;
          end
        end
        wsc_pkg::WSC_ST_SLEEP: begin
          if (wake_evt) begin
            next_state = wsc_pkg::WSC_ST_WAKE;
          end
        end
        wsc_pkg::WSC_ST_WAKE: begin
          if (cmd_normal) begin
            next_state = wsc_pkg::WSC_ST_NORMAL;
          end else if (cmd_sleep) begin
            next_state = wsc_pkg::WSC_ST_TO_SLEEP;
          end else if (cmd_stby) begin
            next_state = wsc_pkg::WSC_ST_TO_STBY;
          end
        end
        wsc_pkg::WSC_ST_TO_STBY: begin
          if (wake_evt) begin
            next_state = wsc_pkg::WSC_ST_INIT;
            next_rst   = 1'b1;
          end else if (trans_done) begin
            next_state = wsc_pkg::WSC_ST_STANDBY;
          end
        end
        wsc_pkg::WSC_ST_STANDBY: begin
          if (wake_evt) begin
            next_state = wsc_pkg::WSC_ST_INIT;
          end
        end
        wsc_pkg::WSC_ST_FAILSAFE: begin
          if (wake_evt) begin
            next_state = wsc_pkg::WSC_ST_INIT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= wsc_pkg::WSC_ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // interrupt and reset output pulses
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wake_irq <= 1'b0;
    end else begin
      wake_irq <= next_irq;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_cnt <= RST_LOAD;
    end else if (next_rst) begin
      rst_cnt <= RST_LOAD;
    end else if (rst_cnt != '0) begin
      rst_cnt <= rst_cnt - `WSC_RST_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reset_output_n <= 1'b0;
    end else begin
      reset_output_n <= !next_rst && (rst_cnt <= `WSC_RST_W'(1));
    end
  end

  // ----------------------------------------------------------------
  // assertions and helper
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      post_rst <= 1'b1;
    end else begin
      post_rst <= 1'b0;
    end
  end

  property p_por_init;
    @(posedge core_clk) disable iff (!rstn)
      post_rst |-> state == wsc_pkg::WSC_ST_INIT && !reset_output_n;
  endproperty
  a_por_init: assert property (p_por_init)
    else $error("not in init with reset low after power-on");
  property p_init_hold;
    @(posedge core_clk) disable iff (!rstn)
      (state == wsc_pkg::WSC_ST_INIT && !cmd_normal && !failsafe_req)
      |=> state == wsc_pkg::WSC_ST_INIT;
  endproperty
  a_init_hold: assert property (p_init_hold)
    else $error("init left without normal command");
  property p_sleep_cmd;
    @(posedge core_clk) disable iff (!rstn)
      (state == wsc_pkg::WSC_ST_NORMAL && cmd_sleep && !failsafe_req)
      |=> state == wsc_pkg::WSC_ST_TO_SLEEP;
  endproperty
  a_sleep_cmd: assert property (p_sleep_cmd)
    else $error("sleep command not taken");
  property p_lvl_qual;
    @(posedge core_clk) disable iff (!rstn)
      $rose(wake_lvl_ok) |-> $past(wake_lvl, 8) && $past(wake_lvl, 1);
  endproperty
  a_lvl_qual: assert property (p_lvl_qual)
    else $error("wake level qualified too early");
  property p_edge_wake;
    @(posedge core_clk) disable iff (!rstn)
      (state == wsc_pkg::WSC_ST_SLEEP && edge_rise && !failsafe_req)
      |=> state == wsc_pkg::WSC_ST_WAKE;
  endproperty
  a_edge_wake: assert property (p_edge_wake)
    else $error("enable edge did not wake from sleep");
  property p_stby_wake;
    @(posedge core_clk) disable iff (!rstn)
      (state inside {wsc_pkg::WSC_ST_STANDBY, wsc_pkg::WSC_ST_FAILSAFE}
       && wake_evt && !failsafe_req) |=> state == wsc_pkg::WSC_ST_INIT;
  endproperty
  a_stby_wake: assert property (p_stby_wake)
    else $error("wake did not lead to init");
  property p_no_wake_hold;
    @(posedge core_clk) disable iff (!rstn)
      (state == wsc_pkg::WSC_ST_SLEEP && !wake_lvl_ok && !edge_rise &&
       !failsafe_req) |=> state == wsc_pkg::WSC_ST_SLEEP;
  endproperty
  a_no_wake_hold: assert property (p_no_wake_hold)
    else $error("sleep left without wake event");
  property p_trans_sleep_wake;
    @(posedge core_clk) disable iff (!rstn)
      (state == wsc_pkg::WSC_ST_TO_SLEEP && wake_evt && !failsafe_req)
      |=> state == wsc_pkg::WSC_ST_WAKE && wake_irq ##1 !wake_irq;
  endproperty
  a_trans_sleep_wake: assert property (p_trans_sleep_wake)
    else $error("wake during sleep entry mishandled");
  property p_trans_stby_rst;
    @(posedge core_clk) disable iff (!rstn)
      (state == wsc_pkg::WSC_ST_TO_STBY && wake_evt && !failsafe_req)
      |=> (state == wsc_pkg::WSC_ST_INIT && !reset_output_n) [*4];
  endproperty
  a_trans_stby_rst: assert property (p_trans_stby_rst)
    else $error("wake during standby entry gave no reset");
  property p_stby_edge_high;
    @(posedge core_clk) disable iff (!rstn)
      (state == wsc_pkg::WSC_ST_NORMAL && cmd_stby && !cmd_sleep &&
       edge_lvl && !failsafe_req) |=> state == wsc_pkg::WSC_ST_TO_STBY;
  endproperty
  a_stby_edge_high: assert property (p_stby_edge_high)
    else $error("standby command blocked by enable level");
  property p_sync_delay;
    @(posedge core_clk) disable iff (!rstn)
      $rose(wake_lvl) |-> !wake_lvl_ok ##1 !wake_lvl_ok;
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("wake level accepted without counting");

endmodule

/* wsc_host_model.sv */
`timescale 1ns/100ps
`include "wsc_defs.svh"

// ----------------------------------------------------------------
// host and wake source model
// ----------------------------------------------------------------
module wsc_host_model #(
  parameter int EDGE_HIGH_CYC = `WSC_EDGE_HIGH_US * `WSC_CLK_MHZ
) (
  input  wire logic         core_clk,
  output wsc_pkg::wsc_cmd_t host_cmd,
  output logic              wake_level_input,
  output logic              enable_edge_input
);
  int edge_cnt;

  initial begin
    host_cmd = '{valid: 1'h0, code: wsc_pkg::WSC_CMD_NONE};
    wake_level_input = 1'h0;
    enable_edge_input = 1'h0;
  end

  always_ff @(posedge core_clk) begin
    edge_cnt <= enable_edge_input ? edge_cnt + 1 : 0;
  end

  task automatic send(input wsc_pkg::wsc_cmd_code_t c);
    @(posedge core_clk);
    host_cmd <= '{valid: 1'h1, code: c};
    @(posedge core_clk);
    host_cmd <= '{valid: 1'h0, code: wsc_pkg::WSC_CMD_NONE};
  endtask

  task automatic edge_up();
    @(posedge core_clk);
    enable_edge_input <= 1'h1;
  endtask

  task automatic edge_down();
    @(posedge core_clk);
    while (edge_cnt < EDGE_HIGH_CYC) @(posedge core_clk);
    enable_edge_input <= 1'h0;
  endtask

  task automatic wake_set(input logic v);
    @(posedge core_clk);
    wake_level_input <= v;
  endtask
endmodule

/* tb_wsc_wake_ctrl.sv */
`timescale 1ns/100ps
`include "wsc_defs.svh"

module tb_wsc_wake_ctrl;
  localparam int WMIN  = 10;
  localparam int TRANS = `WSC_TRANS_CYC;
  localparam int RSTC  = `WSC_RST_CYC;

  logic                core_clk;
  logic                rstn;
  logic                failsafe_req;
  logic                wake_level_input;
  logic                enable_edge_input;
  logic                wake_irq;
  logic                reset_output_n;
  wsc_pkg::wsc_cmd_t   host_cmd;
  wsc_pkg::wsc_state_t state;
  int                  errors;
  int                  samples_checked;

  wsc_wake_ctrl #(
    .WAKE_MIN_CYC (WMIN)
  ) i_dut (
    .core_clk          (core_clk),
    .rstn              (rstn),
    .host_cmd          (host_cmd),
    .failsafe_req      (failsafe_req),
    .wake_level_input  (wake_level_input),
    .enable_edge_input (enable_edge_input),
    .state             (state),
    .wake_irq          (wake_irq),
    .reset_output_n    (reset_output_n)
  );

  wsc_host_model i_host (
    .core_clk          (core_clk),
    .host_cmd          (host_cmd),
    .wake_level_input  (wake_level_input),
    .enable_edge_input (enable_edge_input)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [2:0] seen, input logic [2:0] exp,
                       input string msg);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s %0h not %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic wait_st(input wsc_pkg::wsc_state_t st, input int max);
    int n;
    n = 0;
    while (state !== st && n < max) begin
      @(negedge core_clk);
      n++;
    end
    check(state, st, "state");
  endtask

  task automatic wrap_up();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rstn <= 1'h0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check(state, wsc_pkg::WSC_ST_INIT, "reset state");
    check(reset_output_n, 1'h0, "reset out");
    @(posedge core_clk);
    rstn <= 1'h1;
    @(negedge core_clk);
    check(reset_output_n, 1'h0, "reset out after");
    repeat (RSTC + 2) @(negedge core_clk);
    check(reset_output_n, 1'h1, "reset out end");
    check(state, wsc_pkg::WSC_ST_INIT, "idle init");
  endtask

  task automatic t_init_cmd();
    i_host.send(wsc_pkg::WSC_CMD_SLEEP);
    i_host.send(wsc_pkg::WSC_CMD_STANDBY);
    i_host.send(wsc_pkg::WSC_CMD_NONE);
    @(negedge core_clk);
    check(state, wsc_pkg::WSC_ST_INIT, "init refuses");
    i_host.send(wsc_pkg::WSC_CMD_NORMAL);
    @(negedge core_clk);
    check(state, wsc_pkg::WSC_ST_NORMAL, "to normal");
  endtask

  task automatic t_sleep_level();
    i_host.edge_up();
    repeat (10) @(posedge core_clk);
    i_host.send(wsc_pkg::WSC_CMD_SLEEP);
    @(negedge core_clk);
    check(state, wsc_pkg::WSC_ST_TO_SLEEP, "sleep, enable high");
    wait_st(wsc_pkg::WSC_ST_SLEEP, TRANS + 4);
    i_host.edge_down();
    repeat (8) @(negedge core_clk);
    check(state, wsc_pkg::WSC_ST_SLEEP, "enable fall");
    i_host.wake_set(1'h1);
    repeat (4) @(posedge core_clk);
    i_host.wake_set(1'h0);
    repeat (WMIN + 8) @(negedge core_clk);
    check(state, wsc_pkg::WSC_ST_SLEEP, "short level");
    i_host.wake_set(1'h1);
    wait_st(wsc_pkg::WSC_ST_WAKE, WMIN + 10);
    i_host.wake_set(1'h0);
    repeat (6) @(posedge core_clk);
  endtask

  task automatic t_stby_ena();
    i_host.edge_up();
    repeat (10) @(posedge core_clk);
    i_host.send(wsc_pkg::WSC_CMD_STANDBY);
    @(negedge core_clk);
    check(state, wsc_pkg::WSC_ST_TO_STBY, "standby, enable high");
    wait_st(wsc_pkg::WSC_ST_STANDBY, TRANS + 4);
    i_host.edge_down();
    repeat (8) @(negedge core_clk);
    check(state, wsc_pkg::WSC_ST_STANDBY, "standby enable fall");
    i_host.edge_up();
    wait_st(wsc_pkg::WSC_ST_INIT, 10);
    i_host.edge_down();
  endtask

  task automatic t_abort_sleep();
    i_host.send(wsc_pkg::WSC_CMD_NORMAL);
    i_host.send(wsc_pkg::WSC_CMD_SLEEP);
    repeat (3) @(posedge core_clk);
    i_host.edge_up();
    wait_st(wsc_pkg::WSC_ST_WAKE, 10);
    check(wake_irq, 1'h1, "irq");
    @(negedge core_clk);
    check(wake_irq, 1'h0, "irq pulse");
    i_host.edge_down();
  endtask

  task automatic t_sleep_edge();
    i_host.send(wsc_pkg::WSC_CMD_SLEEP);
    wait_st(wsc_pkg::WSC_ST_SLEEP, TRANS + 4);
    i_host.edge_up();
    wait_st(wsc_pkg::WSC_ST_WAKE, 10);
    check(wake_irq, 1'h0, "no irq from sleep");
    i_host.edge_down();
  endtask

  task automatic t_abort_stby();
    i_host.send(wsc_pkg::WSC_CMD_STANDBY);
    repeat (3) @(posedge core_clk);
    i_host.edge_up();
    wait_st(wsc_pkg::WSC_ST_INIT, 10);
    @(negedge core_clk);
    check(reset_output_n, 1'h0, "abort reset");
    repeat (RSTC + 2) @(negedge core_clk);
    check(reset_output_n, 1'h1, "abort reset end");
    i_host.edge_down();
  endtask

  task automatic t_failsafe();
    @(posedge core_clk);
    failsafe_req <= 1'h1;
    @(posedge core_clk);
    failsafe_req <= 1'h0;
    @(negedge core_clk);
    check(state, wsc_pkg::WSC_ST_FAILSAFE, "failsafe");
    i_host.wake_set(1'h1);
    wait_st(wsc_pkg::WSC_ST_INIT, WMIN + 10);
    i_host.wake_set(1'h0);
    i_host.send(wsc_pkg::WSC_CMD_NORMAL);
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, main
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    wrap_up();
  end

  initial begin
    rstn = 1'h0;
    failsafe_req = 1'h0;
    errors = 0;
    samples_checked = 0;
    t_reset();
    t_init_cmd();
    t_sleep_level();
    t_stby_ena();
    t_abort_sleep();
    t_sleep_edge();
    t_abort_stby();
    t_failsafe();
    t_reset();
    wrap_up();
  end
endmodule
